// ===== verilog/cti_regs.sv
// trap summary, interrupt clear, serial receive, mode and buffer flush registers
`include "cti_map.svh"
`default_nettype none
module cti_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire cti_pkg::cti_req_t req,
    output logic [63:0] rdata,
    output logic rvalid,
    input wire logic boot_rom_data_pin,
    input wire logic icache_loaded,
    input wire logic pal_mode,
    input wire logic [3:0] irq_enable,
    input wire logic pc0_event,
    input wire logic pc1_event,
    input wire logic crd_event,
    input wire cti_pkg::cti_trap_t trap,
    input wire logic itb_fill,
    input wire logic itb_fill_global,
    output logic [3:0] irq_pending,
    output logic irq_take,
    output logic serial_in_bit,
    output logic [1:0] priv_level_field,
    output logic [7:0] itb_valid,
    output logic [2:0] replace_pointer
);
    localparam int CLR_POS [4] = '{`CTI_CLR_SLC, `CTI_CLR_PC0, `CTI_CLR_PC1, `CTI_CLR_CRD};
    localparam int DLY = `CTI_MSK_DELAY;

    logic [7:0] glob_r;
    logic [6:0] sum_r;
    logic [6:0] sum_nxt;
    logic blocked_r;
    logic blocked_nxt;
    logic [63:0] mask_r;
    logic [63:0] mask_nxt;
    logic [5:0] ptr_r;
    logic [DLY-1:0] rd_dly_r;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [3:0] pend_nxt;
    logic [63:0] rd_word;

    // access decode
    wire wr_clr = req.wr && req.sel == `CTI_SEL_CLR;
    wire wr_fla = req.wr && req.sel == `CTI_SEL_FLA;
    wire wr_flb = req.wr && req.sel == `CTI_SEL_FLB;
    wire wr_fng = req.wr && req.sel == `CTI_SEL_FNG;
    wire wr_ps = req.wr && req.sel == `CTI_SEL_PS;
    wire wr_sum = req.wr && req.sel == `CTI_SEL_SUM;
    wire rd_sum = req.rd && req.sel == `CTI_SEL_SUM;
    wire flush_all = wr_fla || wr_flb; // value written is ignored
    wire [5:0] win_idx = ~ptr_r; // order f31..f0 then i31..i0
    wire step = rd_dly_r[DLY-1];

    // receive bit tracks the pin only once the cache load is done
    wire rcv_nxt = icache_loaded & boot_rom_data_pin;
    wire rcv_edge = rcv_nxt ^ serial_in_bit; // either direction

    // request sources; software pacing of bits is outside this block
    assign ev[`CTI_IRQ_SER] = rcv_edge;
    assign ev[`CTI_IRQ_PC0] = pc0_event;
    assign ev[`CTI_IRQ_PC1] = pc1_event;
    assign ev[`CTI_IRQ_CRD] = crd_event;

    // per-request clear: zero clears, one leaves it; events win over clears
    genvar gi;
    generate
        for (gi = 0; gi < `CTI_IRQ_N; gi++) begin : g_irq
            assign clr[gi] = wr_clr && !req.wdata[CLR_POS[gi]];
            assign pend_nxt[gi] = ev[gi] | (irq_pending[gi] & ~clr[gi]);
        end
    endgenerate

    // interrupt taken only when enabled and not in firmware mode
    wire take_nxt = |(pend_nxt & irq_enable) && !pal_mode;

    // request and receive flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_pending <= 4'h0;
            irq_take <= 1'b0;
            serial_in_bit <= 1'b0;
        end else if (ce) begin
            irq_pending <= pend_nxt;
            irq_take <= take_nxt;
            serial_in_bit <= rcv_nxt;
        end
    end

    // mode bits; all other write bits are ignored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            priv_level_field <= 2'h0;
        end else if (ce && wr_ps) begin
            priv_level_field <= {req.wdata[`CTI_PS_W_CM1], req.wdata[`CTI_PS_W_CM0]};
        end
    end

    // translation buffer valid and global flags, one slot each
    // firmware-mode discipline for flushes is left to software
    generate
        for (gi = 0; gi < `CTI_ITB_N; gi++) begin : g_itb
            wire fill_here = itb_fill && replace_pointer == 3'(gi);
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    itb_valid[gi] <= 1'b0;
                    glob_r[gi] <= 1'b0;
                end else if (ce) begin
                    if (flush_all) begin
                        itb_valid[gi] <= 1'b0;
                    end else if (wr_fng && !glob_r[gi]) begin
                        itb_valid[gi] <= 1'b0;
                    end else if (fill_here) begin
                        itb_valid[gi] <= 1'b1;
                        glob_r[gi] <= itb_fill_global;
                    end
                end
            end
        end
    endgenerate

    // replacement pointer steps per fill, back to zero on full flush
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            replace_pointer <= 3'h0;
        end else if (ce) begin
            if (flush_all) begin
                replace_pointer <= 3'h0;
            end else if (itb_fill) begin
                replace_pointer <= replace_pointer + 3'h1;
            end
        end
    end

    // trap flags: write clears, a trap in the same cycle still lands
    always_comb begin
        sum_nxt = wr_sum ? 7'h00 : sum_r;
        blocked_nxt = wr_sum ? 1'b0 : blocked_r;
        if (trap.valid) begin
            sum_nxt[6:1] = sum_nxt[6:1] | trap.flags;
            if (trap.float_op && trap.soft_qual && !blocked_nxt) begin
                sum_nxt[0] = 1'b1;
            end else if (trap.float_op && !trap.soft_qual) begin
                sum_nxt[0] = 1'b0;
                blocked_nxt = 1'b1;
            end
        end
    end

    // write mask: step clears the shown bit, a new trap bit wins
    always_comb begin
        mask_nxt = mask_r; // writes leave it alone
        if (step) begin
            mask_nxt[win_idx] = 1'b0;
        end
        if (trap.valid) begin
            mask_nxt[trap.dest] = 1'b1;
        end
    end

    // summary state, mask and window pointer
    // reads closer than the delay see the same bit again
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sum_r <= 7'h00;
            blocked_r <= 1'b0;
            mask_r <= 64'h0000_0000_0000_0000;
            ptr_r <= 6'h00;
            rd_dly_r <= '0;
        end else if (ce) begin
            sum_r <= sum_nxt;
            blocked_r <= blocked_nxt;
            mask_r <= mask_nxt;
            rd_dly_r <= {rd_dly_r[DLY-2:0], rd_sum};
            if (step) begin
                ptr_r <= ptr_r + 6'h01;
            end
        end
    end

    // read data selection; unmapped and write-only reads give zero
    always_comb begin
        rd_word = 64'h0000_0000_0000_0000;
        case (req.sel)
            `CTI_SEL_RCV: rd_word[`CTI_RCV_BIT] = serial_in_bit;
            `CTI_SEL_PS: begin
                rd_word[`CTI_PS_R_CM1] = priv_level_field[1];
                rd_word[`CTI_PS_R_CM0] = priv_level_field[0];
            end
            `CTI_SEL_SUM: begin
                rd_word[`CTI_SUM_HI:`CTI_SUM_LO] = sum_r;
                rd_word[`CTI_SUM_MSK] = mask_r[win_idx];
            end
            default: rd_word = 64'h0000_0000_0000_0000;
        endcase
    end

    // read data registered, one cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 64'h0000_0000_0000_0000;
            rvalid <= 1'b0;
        end else if (ce) begin
            rdata <= req.rd ? rd_word : 64'h0000_0000_0000_0000;
            rvalid <= req.rd;
        end
    end

    // checks next to the logic
    clr_drops_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        wr_clr && !req.wdata[`CTI_CLR_CRD] && !crd_event |=> !irq_pending[`CTI_IRQ_CRD])
        else $error("clear bit zero did not drop request");
    clr_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        wr_clr && req.wdata[`CTI_CLR_SLC] && irq_pending[`CTI_IRQ_SER]
        |=> irq_pending[`CTI_IRQ_SER])
        else $error("clear bit one changed a request");
    serial_edge_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        icache_loaded && boot_rom_data_pin != serial_in_bit
        |=> irq_pending[`CTI_IRQ_SER] && serial_in_bit == $past(boot_rom_data_pin))
        else $error("receive transition lost");
    pal_block_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        pal_mode |=> !irq_take)
        else $error("interrupt taken in firmware mode");
    serial_mask_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        !irq_enable[`CTI_IRQ_SER] && irq_enable[3:1] == 3'h0 |=> !irq_take)
        else $error("disabled serial request taken");
    itb_flush_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        flush_all |=> itb_valid == 8'h00 && replace_pointer == 3'h0)
        else $error("full flush incomplete");
    itb_nonglobal_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        wr_fng && !flush_all |=> (itb_valid & ~glob_r) == 8'h00
        && (itb_valid & glob_r) == ($past(itb_valid) & glob_r))
        else $error("nonglobal flush wrong");
    ps_write_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        wr_ps |=> priv_level_field == {$past(req.wdata[4]), $past(req.wdata[3])})
        else $error("mode bits not taken");
    sum_clear_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        wr_sum && !trap.valid && !step |=> sum_r == 7'h00 && mask_r == $past(mask_r))
        else $error("summary write wrong");
    mask_step_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        rd_sum && rd_dly_r == '0 |=> ##1 ptr_r == $past(ptr_r, 2) ##1
        ptr_r == $past(ptr_r, 3) ##1 ptr_r == 6'($past(ptr_r, 4) + 6'h01))
        else $error("mask step not three cycles after read");
    swc_hold_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        blocked_r && !wr_sum |=> !sum_r[0])
        else $error("soft completion set while blocked");
endmodule
`default_nettype wire

// ===== common/cti_map.svh
// register select codes, field positions and counts for the trap and clear registers
`ifndef CTI_MAP_SVH
`define CTI_MAP_SVH
// register select codes on the internal register port
`define CTI_SEL_CLR 3'h0
`define CTI_SEL_RCV 3'h1
`define CTI_SEL_FLA 3'h2
`define CTI_SEL_FNG 3'h3
`define CTI_SEL_FLB 3'h4
`define CTI_SEL_PS 3'h5
`define CTI_SEL_SUM 3'h6
// clear bit positions in interrupt_source_clear
`define CTI_CLR_SLC 32
`define CTI_CLR_PC1 15
`define CTI_CLR_PC0 8
`define CTI_CLR_CRD 0
// request vector indices
`define CTI_IRQ_SER 0
`define CTI_IRQ_PC0 1
`define CTI_IRQ_PC1 2
`define CTI_IRQ_CRD 3
`define CTI_IRQ_N 4
// serial_receive_bit position
`define CTI_RCV_BIT 3
// current_mode_status positions
`define CTI_PS_W_CM1 4
`define CTI_PS_W_CM0 3
`define CTI_PS_R_CM1 34
`define CTI_PS_R_CM0 1
// arith_trap_summary positions
`define CTI_SUM_MSK 33
`define CTI_SUM_LO 2
`define CTI_SUM_HI 8
`define CTI_SUM_N 7
// cycles from a summary read to the mask clear and step
`define CTI_MSK_DELAY 3
// translation buffer entries
`define CTI_ITB_N 8
`endif

// ===== common/cti_pkg.sv
// carrier types for the trap and clear registers
`default_nettype none
package cti_pkg;
    // one internal register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
        logic [63:0] wdata;
    } cti_req_t;
    // one arithmetic trap report; flags are iov,ine,unf,fov,dze,inv
    typedef struct packed {
        logic valid;
        logic float_op;
        logic soft_qual;
        logic [5:0] flags;
        logic [5:0] dest;
    } cti_trap_t;
endpackage
`default_nettype wire

// ===== testbench/cti_line_model.sv
// serial line source driving the boot rom data pin
`default_nettype none
module cti_line_model #(
    parameter int BIT_CYC = 8
) (
    input wire logic mclk,
    input wire logic go,
    input wire logic [7:0] byte_in,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_r;
    int cnt_r = 0;
    initial pin = 1'b1;
    // lsb first, each bit held BIT_CYC cycles; the device adds no bit timing
    always @(posedge mclk) begin
        if (go) begin
            sh_r <= byte_in >> 1;
            pin <= byte_in[0];
            cnt_r <= 8 * BIT_CYC - 1;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r % BIT_CYC == 0) begin
                pin <= sh_r[0];
                sh_r <= sh_r >> 1;
            end
        end else begin
            pin <= 1'b1; // mark level between frames
        end
    end
endmodule
`default_nettype wire

// ===== testbench/cti_regs_test.sv
// self-checking bench for the trap and clear registers
`include "cti_map.svh"
`default_nettype none
module cti_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_n, ce, rvalid, pin, icache_loaded, pal_mode, irq_take, serial_in_bit;
    logic pc0_event, pc1_event, crd_event, itb_fill, itb_fill_global, go;
    logic [3:0] irq_enable, irq_pending;
    logic [1:0] priv_level_field;
    logic [7:0] itb_valid;
    logic [2:0] replace_pointer;
    logic [63:0] rdata, d;
    logic [5:0] f, g;
    cti_pkg::cti_req_t req;
    cti_pkg::cti_trap_t trap;
    logic [63:0] expq[$];
    logic [31:0] seed = 32'haee1;
    int miscompares = 0;
    int compares = 0;
    logic [7:0] tx = 8'h5a;
    logic [63:0] clr_d[4];
    logic [3:0] clr_e[4] = '{4'he, 4'hc, 4'h8, 4'h0};
    cti_regs cti_regs_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata),
        .rvalid(rvalid), .boot_rom_data_pin(pin), .icache_loaded(icache_loaded),
        .pal_mode(pal_mode), .irq_enable(irq_enable), .pc0_event(pc0_event),
        .pc1_event(pc1_event), .crd_event(crd_event), .trap(trap), .itb_fill(itb_fill),
        .itb_fill_global(itb_fill_global), .irq_pending(irq_pending), .irq_take(irq_take),
        .serial_in_bit(serial_in_bit), .priv_level_field(priv_level_field),
        .itb_valid(itb_valid), .replace_pointer(replace_pointer));
    cti_line_model cti_line_model_inst (.mclk(mclk), .go(go), .byte_in(tx), .pin(pin));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [63:0] sum(input logic m, input logic [5:0] fl, input logic s);
        return {30'h0, m, 24'h0, fl, s, 2'b0};
    endfunction
    task automatic end_sim();
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one register access; a read notes its expected word, spacing keeps mask steps apart
    task automatic acc(input logic w, input logic [2:0] s, input logic [63:0] wd,
        input logic [63:0] e);
        @(posedge mclk);
        req <= '{wr: w, rd: !w, sel: s, wdata: wd};
        if (!w) expq.push_back(e);
        @(posedge mclk);
        req <= '0;
        tick(3);
    endtask
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            itb_fill <= 1'b1;
            itb_fill_global <= i[0];
        end
        @(posedge mclk);
        itb_fill <= 1'b0;
        tick(1);
    endtask
    task automatic trp(input logic sq, input logic [5:0] fl, input logic [5:0] dst);
        @(posedge mclk);
        trap <= '{valid: 1'b1, float_op: 1'b1, soft_qual: sq, flags: fl, dest: dst};
        @(posedge mclk);
        trap <= '0;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        tick(20000);
        miscompares++;
        end_sim();
    end
    // read words come back in issue order
    always @(posedge mclk) begin
        if (rvalid === 1'b1) check(rdata, (expq.size() > 0) ? expq.pop_front() : 64'hx);
    end
    initial begin
        {rst_n, pal_mode, icache_loaded, pc0_event, pc1_event, crd_event} = '0;
        {itb_fill, itb_fill_global, go, irq_enable, req, trap} = '0;
        ce = 1'b1;
        clr_d = '{'1, ~(64'h1 << `CTI_CLR_PC0), ~(64'h1 << `CTI_CLR_PC1), ~64'h1};
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        check(64'(serial_in_bit), 64'h0);
        for (int i = 0; i < 4; i++) begin
            d = {rnd(), rnd()};
            d[4:3] = i[1:0];
            acc(1'b1, `CTI_SEL_PS, d, 64'h0);
            check(64'(priv_level_field), 64'(i));
            acc(1'b0, `CTI_SEL_PS, d, {29'h0, d[4], 32'h0, d[3], 1'b0});
        end
        acc(1'b0, `CTI_SEL_CLR, 64'h0, 64'h0);
        acc(1'b0, 3'h7, 64'h0, 64'h0);
        {pc0_event, pc1_event, crd_event} <= 3'b111;
        tick(1);
        {pc0_event, pc1_event, crd_event} <= 3'b000;
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, `CTI_SEL_CLR, clr_d[i], 64'h0);
            check(64'(irq_pending), 64'(clr_e[i]));
        end
        icache_loaded <= 1'b1;
        tick(3);
        acc(1'b1, `CTI_SEL_CLR, 64'h0, 64'h0);
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(3);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, `CTI_SEL_RCV, 64'h0, 64'(tx[i]) << `CTI_RCV_BIT);
            tick(3);
        end
        check(64'(irq_pending), 64'h1);
        check(64'(irq_take), 64'h0);
        irq_enable <= 4'h1;
        tick(2);
        check(64'(irq_take), 64'h1);
        pal_mode <= 1'b1; // flushes below are issued in firmware mode
        tick(2);
        check(64'(irq_take), 64'h0);
        fill(8);
        acc(1'b1, `CTI_SEL_FNG, {rnd(), rnd()}, 64'h0);
        check(64'(itb_valid), 64'(8'haa));
        acc(1'b1, `CTI_SEL_FLA, {rnd(), rnd()}, 64'h0);
        check(64'({itb_valid, replace_pointer}), 64'h0);
        fill(3);
        check(64'({itb_valid, replace_pointer}), 64'({8'h07, 3'h3}));
        acc(1'b1, `CTI_SEL_FLB, {rnd(), rnd()}, 64'h0);
        check(64'({itb_valid, replace_pointer}), 64'h0);
        f = 6'(rnd());
        g = 6'(rnd());
        trp(1'b1, f, 6'd62);
        acc(1'b0, `CTI_SEL_SUM, 64'h0, sum(1'b0, f, 1'b1));
        acc(1'b0, `CTI_SEL_SUM, 64'h0, sum(1'b1, f, 1'b1));
        trp(1'b0, g, 6'd60);
        trp(1'b1, g, 6'd59);
        acc(1'b0, `CTI_SEL_SUM, 64'h0, sum(1'b0, f | g, 1'b0));
        acc(1'b1, `CTI_SEL_SUM, {rnd(), rnd()}, 64'h0);
        acc(1'b0, `CTI_SEL_SUM, 64'h0, sum(1'b1, 6'h0, 1'b0));
        acc(1'b0, `CTI_SEL_SUM, 64'h0, sum(1'b1, 6'h0, 1'b0));
        acc(1'b0, `CTI_SEL_SUM, 64'h0, sum(1'b0, 6'h0, 1'b0));
        tick(4);
        end_sim();
    end
endmodule
`default_nettype wire
